// [include/ptcp_pkg.sv]
// Purpose: constants and types of the 10-bit periodic timer block
// Assumes: byte registers on a plain strobe port
// Notes: register index = byte offset on the local port
package ptcp_pkg;

  // ********************
  // widths and limits
  // ********************
  localparam int CW = 10;
  localparam int AW = 4;
  localparam int DW = 8;
  localparam int DIVW = 8;
  localparam logic [CW-1:0] CNT_MAX = 10'h3FF;
  localparam logic [CW:0] PER_FULL = 11'h400; // period 0 means 1024
  // count clock = mclk / 4 by default
  localparam int MCLK_HZ = 20_000_000;
  localparam int CNT_HZ = 5_000_000;
  localparam logic [DIVW-1:0] DIV_DEF = DIVW'(MCLK_HZ / CNT_HZ);

  // ********************
  // register indices
  // ********************
  localparam logic [AW-1:0] REG_CTRL0 = 4'h0;
  localparam logic [AW-1:0] REG_CTRL1 = 4'h1;
  localparam logic [AW-1:0] REG_CNT_LO = 4'h2;
  localparam logic [AW-1:0] REG_CNT_HI = 4'h3;
  localparam logic [AW-1:0] REG_CMPA_LO = 4'h4;
  localparam logic [AW-1:0] REG_CMPA_HI = 4'h5;
  localparam logic [AW-1:0] REG_PER_LO = 4'h6;
  localparam logic [AW-1:0] REG_PER_HI = 4'h7;
  localparam logic [AW-1:0] REG_FLAGS = 4'h8;

  // ********************
  // field positions
  // ********************
  localparam int RUN_BIT = 3;
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_P_BIT = 1;
  localparam int HI_W = 2; // implemented bits of a high register

  // ********************
  // modes and actions
  // ********************
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CAP = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  // compare mode actions
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOG = 2'h3;
  // pwm mode actions
  localparam logic [1:0] PACT_INACT = 2'h0;
  localparam logic [1:0] PACT_ACT = 2'h1;
  localparam logic [1:0] PACT_PWM = 2'h2;
  localparam logic [1:0] PACT_ONE = 2'h3;
  // capture edge selects
  localparam logic [1:0] CACT_RISE = 2'h0;
  localparam logic [1:0] CACT_FALL = 2'h1;
  localparam logic [1:0] CACT_BOTH = 2'h2;

  // ********************
  // types
  // ********************
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } ptcp_req_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] action;
    logic init_lvl;
    logic invert;
    logic cap_src;
    logic clr_src;
  } ptcp_ctrl1_t;

  typedef struct packed {
    logic [DIVW-1:0] div;
    logic run;
    logic run_prev;
    logic [DW-1:0] ctrl1;
    logic [CW-1:0] cnt;
    logic [CW-1:0] cmpa;
    logic [CW-1:0] per;
    logic flag_a;
    logic flag_p;
    logic out_lvl;
    logic pin;
    logic oe_n;
    logic [2:0] cap_prev;
    logic [DW-1:0] rdata;
  } ptcp_state_t;

  localparam ptcp_state_t ST_RST = '{oe_n: 1'b1, default: '0};

endpackage : ptcp_pkg

// [src/ptcp_timer.sv]
// Purpose: 10-bit count-up periodic timer, compare, pwm and capture
// Assumes: inputs synchronous to mclk, one clock domain
// Notes: count clock is a divided enable of mclk
`timescale 1ns/1ns

// How it works
// - compare mode, initial level bit sets pin before any A match.
// - pwm mode, initial level bit picks active high or active low.
// - single pulse, initial level bit sets pin when run goes high.
// - invert bit flips the pin; no effect in timer/counter mode.
// - capture trigger from timer pins at 0, external pin at 1.
// - clear select 1 clears on A match; 0 on P match or overflow.
// - clear select ignored in pwm, single pulse and capture modes.
// - counter readable only, low byte and two high bits.
// - upper six bits of every high register read as zero.
// - mode 00 is compare output; counter cleared by overflow, A or P.
// - compare mode with clear select 0 raises both A and P flags.
// - compare mode with clear select 1 never raises the P flag.
// - compare A zero overflows at 3FF and raises no A flag.
// - compare mode pin changes only on A flag, never on P.
// - A match drives pin high, low, toggles, or leaves it.
// - run rising edge reloads the pin with the initial level.
// - mode 11 acts like compare mode but leaves the pin undriven.
// - mode 10 is pwm; period clears counter, A sets duty.
// - pwm mode raises separate A and P flags on matches.
// - pwm action enables waveform or forces inactive or active level.
// - pwm period zero means 1024; duty at or above period is 100%.
// - run rising clears counter; run falling stops and keeps count.
module ptcp_timer
  import ptcp_pkg::*;
#(
  parameter logic [DIVW-1:0] DIV = DIV_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire ptcp_req_t reg_req,
  output logic [DW-1:0] reg_rdata,
  input wire logic timer_pin_first,
  input wire logic timer_pin_second,
  input wire logic ext_count_pin,
  output logic timer_out,
  output logic timer_out_oe_n,
  output logic match_a_flag,
  output logic match_p_flag
);

  // ********************
  // reset release
  // ********************
  logic [1:0] rst_sync_ff;
  logic rst_q_n;

  // async assert, two-flop release so no flop leaves reset mid-edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_q_n = rst_sync_ff[1];

  // ********************
  // state
  // ********************
  ptcp_state_t st_ff;
  ptcp_state_t nxt_st;
  ptcp_ctrl1_t c1;
  logic tick;
  logic run_rise;
  logic ev_a;
  logic ev_p;
  logic a_hit;
  logic p_hit;
  logic cap_ev;
  logic pwm_act;
  logic lvl;
  logic edge_r;
  logic edge_f;
  logic [2:0] cap_now;
  logic [2:0] rise_v;
  logic [2:0] fall_v;
  logic [CW-1:0] cnt_inc;
  logic [CW:0] per_eff;

  assign c1 = ptcp_ctrl1_t'(st_ff.ctrl1);
  assign cap_now = {ext_count_pin, timer_pin_second, timer_pin_first};

  // ********************
  // next state
  // ********************
  // one process computes the whole next state
  always_comb begin
    nxt_st = st_ff;
    tick = 1'b0;
    ev_a = 1'b0;
    ev_p = 1'b0;
    lvl = 1'b0;
    run_rise = st_ff.run & ~st_ff.run_prev;
    cnt_inc = st_ff.cnt + 1'b1; // wraps 3FF to 0: overflow
    // zero compare values never match, counter just wraps
    a_hit = (st_ff.cmpa == cnt_inc) && (st_ff.cmpa != '0);
    p_hit = (st_ff.per == cnt_inc) && (st_ff.per != '0);
    per_eff = (st_ff.per == '0) ? PER_FULL : {1'b0, st_ff.per};

    // count clock divider
    if (st_ff.div >= DIV - 1'b1) begin
      nxt_st.div = '0;
      tick = 1'b1;
    end else begin
      nxt_st.div = st_ff.div + 1'b1;
    end
    nxt_st.run_prev = st_ff.run;

    // counter: cleared on run rise, frozen while run is low
    if (run_rise) begin
      nxt_st.cnt = '0;
      nxt_st.out_lvl = c1.init_lvl;
    end else if (st_ff.run && tick) begin
      nxt_st.cnt = cnt_inc;
      case (c1.mode)
        MODE_CMP, MODE_TMR: begin
          if (c1.clr_src) begin
            ev_a = a_hit;
            if (a_hit) begin
              nxt_st.cnt = '0;
            end
          end else begin
            ev_a = a_hit;
            ev_p = p_hit;
            if (p_hit) begin
              nxt_st.cnt = '0;
            end
          end
        end
        MODE_PWM: begin
          ev_a = a_hit;
          ev_p = p_hit;
          if (p_hit) begin
            nxt_st.cnt = '0;
          end
          // single pulse ends on an A match by dropping run
          if (c1.action == PACT_ONE && a_hit) begin
            nxt_st.run = 1'b0;
          end
        end
        default: begin // capture: period limits the count
          ev_p = p_hit;
          if (p_hit) begin
            nxt_st.cnt = '0;
          end
        end
      endcase
    end

    // capture trigger edges, sampled every mclk
    nxt_st.cap_prev = cap_now;
    rise_v = cap_now & ~st_ff.cap_prev;
    fall_v = ~cap_now & st_ff.cap_prev;
    edge_r = c1.cap_src ? rise_v[2] : |rise_v[1:0];
    edge_f = c1.cap_src ? fall_v[2] : |fall_v[1:0];
    cap_ev = st_ff.run && (c1.mode == MODE_CAP) &&
      (((c1.action == CACT_RISE) && edge_r) ||
       ((c1.action == CACT_FALL) && edge_f) ||
       ((c1.action == CACT_BOTH) && (edge_r || edge_f)));
    if (cap_ev) begin
      nxt_st.cmpa = st_ff.cnt;
      ev_a = 1'b1;
    end

    // compare mode: only the A event moves the output level
    if (c1.mode == MODE_CMP && ev_a && !run_rise) begin
      case (c1.action)
        ACT_LOW: nxt_st.out_lvl = 1'b0;
        ACT_HIGH: nxt_st.out_lvl = 1'b1;
        ACT_TOG: nxt_st.out_lvl = ~st_ff.out_lvl;
        default: nxt_st.out_lvl = st_ff.out_lvl;
      endcase
    end

    // register writes; hardware flag set still wins below
    if (reg_req.wr) begin
      if (reg_req.addr == REG_CTRL0) begin
        nxt_st.run = reg_req.wdata[RUN_BIT];
      end else if (reg_req.addr == REG_CTRL1) begin
        nxt_st.ctrl1 = reg_req.wdata;
      end else if (reg_req.addr == REG_CMPA_LO) begin
        nxt_st.cmpa[DW-1:0] = reg_req.wdata;
      end else if (reg_req.addr == REG_CMPA_HI) begin
        nxt_st.cmpa[CW-1:DW] = reg_req.wdata[HI_W-1:0];
      end else if (reg_req.addr == REG_PER_LO) begin
        nxt_st.per[DW-1:0] = reg_req.wdata;
      end else if (reg_req.addr == REG_PER_HI) begin
        nxt_st.per[CW-1:DW] = reg_req.wdata[HI_W-1:0];
      end else if (reg_req.addr == REG_FLAGS) begin
        // write one to clear
        if (reg_req.wdata[FLAG_A_BIT]) begin
          nxt_st.flag_a = 1'b0;
        end
        if (reg_req.wdata[FLAG_P_BIT]) begin
          nxt_st.flag_p = 1'b0;
        end
      end
    end
    // sticky flags, set beats a same-cycle clear
    if (ev_a) begin
      nxt_st.flag_a = 1'b1;
    end
    if (ev_p) begin
      nxt_st.flag_p = 1'b1;
    end

    // read data lives for exactly one cycle; unmapped reads zero
    nxt_st.rdata = '0;
    if (reg_req.rd) begin
      if (reg_req.addr == REG_CTRL0) begin
        nxt_st.rdata[RUN_BIT] = st_ff.run;
      end else if (reg_req.addr == REG_CTRL1) begin
        nxt_st.rdata = st_ff.ctrl1;
      end else if (reg_req.addr == REG_CNT_LO) begin
        nxt_st.rdata = st_ff.cnt[DW-1:0];
      end else if (reg_req.addr == REG_CNT_HI) begin
        nxt_st.rdata[HI_W-1:0] = st_ff.cnt[CW-1:DW];
      end else if (reg_req.addr == REG_CMPA_LO) begin
        nxt_st.rdata = st_ff.cmpa[DW-1:0];
      end else if (reg_req.addr == REG_CMPA_HI) begin
        nxt_st.rdata[HI_W-1:0] = st_ff.cmpa[CW-1:DW];
      end else if (reg_req.addr == REG_PER_LO) begin
        nxt_st.rdata = st_ff.per[DW-1:0];
      end else if (reg_req.addr == REG_PER_HI) begin
        nxt_st.rdata[HI_W-1:0] = st_ff.per[CW-1:DW];
      end else if (reg_req.addr == REG_FLAGS) begin
        nxt_st.rdata[FLAG_A_BIT] = st_ff.flag_a;
        nxt_st.rdata[FLAG_P_BIT] = st_ff.flag_p;
      end
    end

    // pin: duty compare against the next count, so edges are on time
    pwm_act = ({1'b0, nxt_st.cnt} < {1'b0, st_ff.cmpa}) ||
      ({1'b0, st_ff.cmpa} >= per_eff);
    nxt_st.oe_n = 1'b0;
    case (c1.mode)
      MODE_CMP: lvl = nxt_st.out_lvl;
      MODE_PWM: begin
        case (c1.action)
          PACT_INACT: lvl = ~c1.init_lvl;
          PACT_ACT: lvl = c1.init_lvl;
          PACT_PWM: lvl = pwm_act ? c1.init_lvl : ~c1.init_lvl;
          default: lvl = nxt_st.run ? c1.init_lvl : ~c1.init_lvl;
        endcase
      end
      default: nxt_st.oe_n = 1'b1; // timer and capture: no drive
    endcase
    // invert only where the pin is driven
    nxt_st.pin = nxt_st.oe_n ? 1'b0 : (lvl ^ c1.invert);
  end

  // ********************
  // state register
  // ********************
  always_ff @(posedge mclk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign timer_out = st_ff.pin;
  assign timer_out_oe_n = st_ff.oe_n;
  assign match_a_flag = st_ff.flag_a;
  assign match_p_flag = st_ff.flag_p;

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_q_n);

  a_run_clears: assert property (
    (st_ff.run && !st_ff.run_prev) |=> (st_ff.cnt == '0))
    else $error("counter not cleared on run rise");

  a_stop_holds: assert property (
    !st_ff.run |=> $stable(st_ff.cnt))
    else $error("counter moved while stopped");

  a_flag_sticky: assert property (
    $fell(st_ff.flag_a) |-> $past(reg_req.wr &&
      reg_req.addr == REG_FLAGS && reg_req.wdata[FLAG_A_BIT]))
    else $error("A flag dropped without clear");

  a_cnt_read: assert property (
    (reg_req.rd && reg_req.addr == REG_CNT_LO) |=>
      (reg_rdata == $past(st_ff.cnt[DW-1:0])))
    else $error("counter low byte read wrong");

  a_hi_zero: assert property (
    (reg_req.rd && (reg_req.addr == REG_CNT_HI ||
      reg_req.addr == REG_CMPA_HI || reg_req.addr == REG_PER_HI))
      |=> (reg_rdata[DW-1:HI_W] == '0))
    else $error("high register upper bits not zero");

  a_no_pflag: assert property (
    (c1.mode == MODE_CMP && c1.clr_src && !st_ff.flag_p) |=>
      !st_ff.flag_p)
    else $error("P flag with clear select on A");

  a_zero_a: assert property (
    (st_ff.cmpa == '0 && c1.mode != MODE_CAP) |-> !ev_a)
    else $error("A event with zero compare A");

  a_timer_undriven: assert property (
    (c1.mode == MODE_TMR) |=> timer_out_oe_n)
    else $error("pin driven in timer mode");

  a_init_level: assert property (
    (c1.mode == MODE_CMP && st_ff.run && !st_ff.run_prev) |=>
      (timer_out == $past(c1.init_lvl ^ c1.invert)))
    else $error("pin not at initial level after run rise");

  a_toggle_a: assert property (
    (c1.mode == MODE_CMP && c1.action == ACT_TOG && ev_a &&
      !run_rise) |=> (st_ff.out_lvl != $past(st_ff.out_lvl)))
    else $error("toggle on A match missed");

  a_pwm_full: assert property (
    (c1.mode == MODE_PWM && c1.action == PACT_PWM &&
      {1'b0, st_ff.cmpa} >= per_eff && !reg_req.wr) |=>
      (timer_out == $past(c1.init_lvl ^ c1.invert)))
    else $error("full duty not held active");

  a_pin_quiet: assert property (
    (c1.mode == MODE_TMR) |=> (timer_out == 1'b0))
    else $error("undriven pin not held low");

  a_pulse_ends: assert property (
    (c1.mode == MODE_PWM && c1.action == PACT_ONE && st_ff.run &&
      tick && a_hit && !run_rise && !reg_req.wr) |=> !st_ff.run)
    else $error("single pulse run not dropped on A match");

endmodule : ptcp_timer

// [tb/tb_top.sv]
// Purpose: self-checking bench of the periodic timer block
// Assumes: counter steps every mclk (DIV of one)
// Notes: random values from an xorshift seeded with 14823
`timescale 1ns/1ns
module tb_top;
  import ptcp_pkg::*;
  // ********************
  // signals and helpers
  // ********************
  logic mclk;
  logic rst_n;
  ptcp_req_t reg_req;
  logic [DW-1:0] reg_rdata;
  logic timer_pin_first;
  logic timer_pin_second;
  logic ext_count_pin;
  logic timer_out;
  logic timer_out_oe_n;
  logic match_a_flag;
  logic match_p_flag;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000_39E7;
  logic [31:0] r;
  logic [7:0] d;
  logic [7:0] d2;

  ptcp_timer #(.DIV(8'h01)) ptcp_timer_inst (
    .mclk(mclk),
    .rst_n(rst_n),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .timer_pin_first(timer_pin_first),
    .timer_pin_second(timer_pin_second),
    .ext_count_pin(ext_count_pin),
    .timer_out(timer_out),
    .timer_out_oe_n(timer_out_oe_n),
    .match_a_flag(match_a_flag),
    .match_p_flag(match_p_flag)
  );

  // free-running 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift

  // pin level after one comparator A match
  function automatic logic cmp_pin(input logic [1:0] act, input logic ini);
    case (act)
      ACT_LOW: return 1'b0;
      ACT_HIGH: return 1'b1;
      ACT_TOG: return ~ini;
      default: return ini;
    endcase
  endfunction : cmp_pin

  // high cycles of the pin over one pwm period
  function automatic int pwm_high(input logic [1:0] act, input int a,
      input int per, input logic lvl);
    int on;
    on = (a >= per) ? per : a;
    if (act == PACT_INACT) on = 0;
    if (act == PACT_ACT) on = per;
    return lvl ? on : per - on;
  endfunction : pwm_high

  // ********************
  // bus and check tasks
  // ********************
  task automatic check(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge mclk);
    reg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    reg_req <= '0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
    @(posedge mclk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    reg_req <= '0;
    #1 v = reg_rdata;
  endtask : rd

  // stop, load compares and control, clear flags, restart
  task automatic cfg(input logic [1:0] md, input logic [1:0] act,
      input logic ini, input logic inv, input logic cap, input logic clr,
      input logic [9:0] a, input logic [9:0] p);
    wr(REG_CTRL0, 8'h00);
    wr(REG_CMPA_LO, a[7:0]);
    wr(REG_CMPA_HI, {6'h00, a[9:8]});
    wr(REG_PER_LO, p[7:0]);
    wr(REG_PER_HI, {6'h00, p[9:8]});
    wr(REG_CTRL1, {md, act, ini, inv, cap, clr});
    wr(REG_FLAGS, 8'h03);
    wr(REG_CTRL0, 8'h08);
  endtask : cfg

  // a full period is counted, so the phase does not matter
  task automatic pwm_case(input logic [1:0] act, input logic ini,
      input logic inv, input logic clr, input logic [9:0] a,
      input logic [9:0] p);
    int per;
    int n;
    int exp_n;
    per = (p == 10'h000) ? 1024 : int'(p);
    n = 0;
    cfg(MODE_PWM, act, ini, inv, 1'b0, clr, a, p);
    tick(per + 4);
    repeat (per) begin
      @(posedge mclk);
      #1 n += int'(timer_out === 1'b1);
    end
    exp_n = pwm_high(act, int'(a), per, ini ^ inv);
    check("pwm_high", 16'(exp_n), 16'(n));
  endtask : pwm_case

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  // hang guard, well above the expected run length
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      $display("Error timeout expected done seen hang");
      print_verdict();
    end
  end

  // ********************
  // main sequence
  // ********************
  initial begin
    reg_req = '0;
    timer_pin_first = 1'b0;
    timer_pin_second = 1'b0;
    ext_count_pin = 1'b0;
    rst_n = 1'b0;
    // pin released only while reset holds; control one resets to mode 00
    tick(4);
    #1 check("oe_n_rst", 16'h1, timer_out_oe_n);
    check("pin_rst", 16'h0, timer_out);
    tick(1);
    rst_n <= 1'b1;
    tick(3);
    #1 check("oe_n_idle", 16'h0, timer_out_oe_n);
    check("pin_idle", 16'h0, timer_out);
    for (int k = 0; k < 9; k++) begin
      rd(4'(k), d);
      check("reset_reg", 16'h0, d);
    end
    rd(4'hF, d);
    check("unmapped", 16'h0, d);
    // random compare values, high registers keep two bits
    for (int k = 0; k < 4; k++) begin
      r = xorshift();
      wr(REG_CMPA_LO, r[7:0]);
      wr(REG_CMPA_HI, r[15:8]);
      wr(REG_PER_LO, r[23:16]);
      wr(REG_PER_HI, r[31:24]);
      wr(REG_CNT_LO, r[7:0]);
      wr(REG_CNT_HI, r[15:8]);
      rd(REG_CMPA_LO, d);
      check("cmpa_lo", r[7:0], d);
      rd(REG_CMPA_HI, d);
      check("cmpa_hi", {6'h00, r[9:8]}, d);
      rd(REG_PER_LO, d);
      check("per_lo", r[23:16], d);
      rd(REG_PER_HI, d);
      check("per_hi", {6'h00, r[25:24]}, d);
      rd(REG_CNT_LO, d);
      check("cnt_lo_ro", 16'h0, d);
      rd(REG_CNT_HI, d);
      check("cnt_hi_ro", 16'h0, d);
    end
    // compare mode: every action, initial level and inversion
    for (int k = 0; k < 16; k++) begin
      r = xorshift();
      cfg(MODE_CMP, k[1:0], k[2], k[3], 1'b0, 1'b0, 10'(2 + r % 30), 10'd40);
      tick(2);
      #1 check("init_pin", k[2] ^ k[3], timer_out);
      check("oe_n_cmp", 16'h0, timer_out_oe_n);
      // look after P clears but before the second A match of small values
      tick(40);
      d = {7'h00, cmp_pin(k[1:0], k[2]) ^ k[3]};
      #1 check("match_pin", d, timer_out);
      check("flags_cmp", 16'h3, {match_p_flag, match_a_flag});
    end
    // stop first so no match can land on the clearing edge
    wr(REG_CTRL0, 8'h00);
    rd(REG_FLAGS, d);
    check("flag_reg", 16'h3, d);
    wr(REG_FLAGS, 8'h03);
    #1 check("flag_clr", 16'h0, {match_p_flag, match_a_flag});
    // clear source: A match with select 1, P match with select 0
    cfg(MODE_CMP, ACT_TOG, 1'b0, 1'b0, 1'b0, 1'b1, 10'd30, 10'd10);
    tick(70);
    rd(REG_CNT_LO, d);
    check("a_only", 16'h1, {match_p_flag, match_a_flag});
    check("clr_by_a", 16'h1, d < 8'd30);
    cfg(MODE_CMP, ACT_TOG, 1'b0, 1'b0, 1'b0, 1'b0, 10'd30, 10'd10);
    tick(70);
    rd(REG_CNT_LO, d);
    check("p_only", 16'h2, {match_p_flag, match_a_flag});
    check("clr_by_p", 16'h1, d < 8'd10);
    // compare A of zero: wraps at 3FF, no A flag, pin untouched
    cfg(MODE_CMP, ACT_TOG, 1'b0, 1'b0, 1'b0, 1'b1, 10'd0, 10'd0);
    tick(1100);
    #1 check("a_zero", 16'h0, match_a_flag);
    check("p_zero", 16'h0, match_p_flag);
    check("pin_zero", 16'h0, timer_out);
    // run falling keeps the count, rising clears it
    cfg(MODE_CMP, ACT_NONE, 1'b0, 1'b0, 1'b0, 1'b0, 10'd0, 10'd0);
    tick(50);
    wr(REG_CTRL0, 8'h00);
    rd(REG_CNT_LO, d);
    tick(10);
    rd(REG_CNT_LO, d2);
    check("cnt_kept", 16'h33, d2);
    check("cnt_nonzero", 16'h1, d > 8'd40);
    wr(REG_CTRL0, 8'h08);
    rd(REG_CNT_LO, d);
    check("cnt_restart", 16'h1, d < 8'd5);
    // timer/counter mode leaves the pin alone but sets both flags
    cfg(MODE_TMR, ACT_TOG, 1'b1, 1'b1, 1'b0, 1'b0, 10'd5, 10'd10);
    tick(30);
    #1 check("oe_n_tmr", 16'h1, timer_out_oe_n);
    check("flags_tmr", 16'h3, {match_p_flag, match_a_flag});
    check("pin_tmr", 16'h0, timer_out);
    // pwm: polarity, forced levels, full duty, period of zero
    pwm_case(PACT_PWM, 1'b1, 1'b0, 1'b0, 10'd4, 10'd16);
    check("flags_pwm", 16'h3, {match_p_flag, match_a_flag});
    pwm_case(PACT_PWM, 1'b0, 1'b0, 1'b1, 10'd4, 10'd16);
    r = xorshift();
    pwm_case(PACT_PWM, 1'b1, 1'b1, 1'b0, 10'(r % 17), 10'd16);
    pwm_case(PACT_PWM, 1'b1, 1'b0, 1'b0, 10'd20, 10'd16);
    pwm_case(PACT_PWM, 1'b1, 1'b0, 1'b0, 10'd256, 10'd0);
    pwm_case(PACT_INACT, 1'b1, 1'b0, 1'b0, 10'd4, 10'd16);
    pwm_case(PACT_ACT, 1'b1, 1'b0, 1'b0, 10'd4, 10'd16);
    // single pulse: active from run rising until the A match
    cfg(MODE_PWM, PACT_ONE, 1'b1, 1'b0, 1'b0, 1'b0, 10'd10, 10'd0);
    tick(2);
    #1 check("pulse_lead", 16'h1, timer_out);
    tick(20);
    #1 check("pulse_trail", 16'h0, timer_out);
    rd(REG_CTRL0, d);
    check("pulse_run", 16'h0, d[RUN_BIT]);
    // capture source: timer pins at 0, external pin at 1
    cfg(MODE_CAP, CACT_RISE, 1'b0, 1'b0, 1'b0, 1'b0, 10'd0, 10'd0);
    tick(10);
    ext_count_pin <= 1'b1;
    tick(10);
    #1 check("cap_ignore_ext", 16'h0, match_a_flag);
    tick(1);
    timer_pin_first <= 1'b1;
    tick(5);
    #1 check("cap_pin", 16'h1, match_a_flag);
    tick(1);
    timer_pin_first <= 1'b0;
    ext_count_pin <= 1'b0;
    cfg(MODE_CAP, CACT_RISE, 1'b0, 1'b0, 1'b1, 1'b0, 10'd0, 10'd0);
    tick(10);
    timer_pin_second <= 1'b1;
    tick(10);
    #1 check("cap_ignore_pin", 16'h0, match_a_flag);
    tick(1);
    ext_count_pin <= 1'b1;
    tick(5);
    #1 check("cap_ext", 16'h1, match_a_flag);
    print_verdict();
  end
endmodule : tb_top
